// File: rtl/spimsp_core.sv
// Byte-wide serial peripheral port that works as master or as slave.
`timescale 1ns/10ps
module spimsp_core
  import spimsp_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic SERIAL_POWER_REDUCE_I, // One keeps the port off.
  input wire logic SERIAL_ENABLE_I,
  input wire logic TRANSFER_IRQ_ENABLE_I,
  input wire logic GLOBAL_IRQ_ENABLE_I,
  input wire logic BIT_ORDER_I, // One sends LSB first.
  input wire logic CLK_POL_I,
  input wire logic CLK_PHA_I,
  input wire logic [1:0] RATE_SEL_I,
  input wire logic DOUBLE_SPEED_I,
  input wire logic MASTER_SELECT_WR_I, // Pulse: write master_select.
  input wire logic MASTER_SELECT_VAL_I,
  input wire logic DATA_WR_I, // Pulse: software writes data.
  input wire logic [7:0] DATA_WDATA_I,
  input wire logic DATA_RD_I, // Pulse: software reads data.
  input wire logic STATUS_RD_I, // Pulse: software reads status.
  input wire logic IRQ_ACK_I, // Pulse: interrupt vector runs.
  input wire logic [3:0] PIN_DIR_OUT_I, // User directions, one = out.
  input wire logic [3:0] PIN_PORT_I, // User output values.
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE_N_O,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE_N_O,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_N_O,
  input wire logic SEL_N_I,
  output logic SEL_N_O,
  output logic SEL_OE_N_O,
  output logic [7:0] RX_DATA_O,
  output logic TRANSFER_DONE_FLAG_O,
  output logic WRITE_COLLISION_FLAG_O,
  output logic MASTER_SELECT_O,
  output logic BUSY_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------------
  // Pin synchronisation.
  // ----------------------------------------------------------------------
  logic [3:0] pins_s; // Synchronised MOSI, MISO, SCK, select.
  logic sck_prev_q; // Previous synchronised clock, for edges.

  spimsp_sync #(
    .WIDTH(4)
  ) u_sync (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .ASYNC_I({SEL_N_I, SCK_I, MISO_I, MOSI_I}),
    .SYNC_O(pins_s)
  );

  // ----------------------------------------------------------------------
  // Mode decode.
  // ----------------------------------------------------------------------
  logic en; // Port is live.
  logic master_q; // Master mode bit.
  logic sel_low; // Select pin seen low.
  logic mode_fault; // Another master pulled our select low.
  logic sel_in_m; // Select pin acts as input in master mode.

  assign en = SERIAL_ENABLE_I & ~SERIAL_POWER_REDUCE_I;
  assign sel_low = ~pins_s[SPIMSP_PIN_SEL];
  assign sel_in_m = ~PIN_DIR_OUT_I[SPIMSP_PIN_SEL];
  assign mode_fault = en & master_q & sel_in_m & sel_low;

  // Half period of the master clock for the chosen rate.
  function automatic logic [6:0] half_count(input logic [1:0] sel,
                                            input logic dbl);
    logic [6:0] h;
    h = SPIMSP_HALF_0;
    case ({dbl, sel})
      3'b000: h = SPIMSP_HALF_0;
      3'b001: h = SPIMSP_HALF_1;
      3'b010: h = SPIMSP_HALF_2;
      3'b011: h = SPIMSP_HALF_3;
      3'b100: h = SPIMSP_HALF_2X_0;
      3'b101: h = SPIMSP_HALF_2X_1;
      3'b110: h = SPIMSP_HALF_2X_2;
      default: h = SPIMSP_HALF_2X_3;
    endcase
    return h;
  endfunction

  // ----------------------------------------------------------------------
  // Master select bit. The fault clear wins over a software set, since a
  // foreign master on the bus must never meet our drivers.
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      master_q <= 1'b0;
    end else if (mode_fault) begin
      master_q <= 1'b0;
    end else if (MASTER_SELECT_WR_I) begin
      master_q <= MASTER_SELECT_VAL_I;
    end
  end

  // ----------------------------------------------------------------------
  // Shift engine: master clock generator and slave edge detection.
  // ----------------------------------------------------------------------
  spimsp_state_t state_q; // Master transfer state.
  logic [6:0] div_q; // Master half-period counter.
  logic [4:0] edge_q; // Master edge index, 0 to 15.
  logic sck_q; // Master clock level.
  logic [3:0] cnt_q; // Slave sampled-bit count.
  logic [7:0] sr_q; // Shift register.
  logic out_bit_q; // Bit presented on the data output.
  logic top_bit; // Next bit to send.
  logic s_lead; // Slave leading edge.
  logic s_trail; // Slave trailing edge.
  logic s_act; // Slave selected and live.
  logic m_tick; // Master edge due this cycle.
  logic m_lead; // Master edge is a leading one.
  logic smp; // A sample edge fires.
  logic setup; // A setup edge fires.
  logic in_bit; // Incoming data bit for the current role.
  logic busy; // A byte is in flight.
  logic done; // A byte just finished.
  logic wr_ok; // Data write that loads the shift register.

  assign top_bit = BIT_ORDER_I ? sr_q[0] : sr_q[SPIMSP_BITS-1];
  assign s_act = en & ~master_q & sel_low;
  assign s_lead = s_act & (sck_prev_q == CLK_POL_I) &
                  (pins_s[SPIMSP_PIN_SCK] != CLK_POL_I);
  assign s_trail = s_act & (sck_prev_q != CLK_POL_I) &
                   (pins_s[SPIMSP_PIN_SCK] == CLK_POL_I);
  assign m_tick = (state_q == SPIMSP_XFER) & (div_q == 7'h01);
  assign m_lead = ~edge_q[0];
  assign in_bit = master_q ? pins_s[SPIMSP_PIN_MISO]
                           : pins_s[SPIMSP_PIN_MOSI];
  // Phase zero samples on the leading edge, phase one on the trailing.
  assign smp = master_q ? (m_tick & (m_lead ^ CLK_PHA_I))
                        : (CLK_PHA_I ? s_trail : s_lead);
  assign setup = master_q ? (m_tick & ~(m_lead ^ CLK_PHA_I))
                          : (CLK_PHA_I ? s_lead : s_trail);
  assign busy = (state_q == SPIMSP_XFER) | (s_act & (cnt_q != 4'h0));
  assign done = master_q ? (m_tick & (edge_q == SPIMSP_LAST_EDGE))
                         : (smp & (cnt_q == SPIMSP_LAST_BIT));
  assign wr_ok = en & DATA_WR_I & ~busy;

  // Previous slave clock sample for edge detection.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= pins_s[SPIMSP_PIN_SCK];
    end
  end

  // Master state, divider, edge index and clock level.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || !en || !master_q) begin
      // Leaving master mode also kills a byte in flight.
      state_q <= SPIMSP_IDLE;
      div_q <= 7'h00;
      edge_q <= 5'h00;
      sck_q <= CLK_POL_I;
    end else begin
      case (state_q)
        SPIMSP_IDLE: begin
          sck_q <= CLK_POL_I; // Idle level follows polarity.
          if (wr_ok) begin
            state_q <= SPIMSP_XFER;
            div_q <= half_count(RATE_SEL_I, DOUBLE_SPEED_I);
            edge_q <= 5'h00;
          end
        end
        default: begin
          if (m_tick) begin
            sck_q <= ~sck_q;
            edge_q <= edge_q + 5'h01;
            div_q <= half_count(RATE_SEL_I, DOUBLE_SPEED_I);
            if (done) begin
              state_q <= SPIMSP_IDLE;
            end
          end else begin
            div_q <= div_q - 7'h01;
          end
        end
      endcase
    end
  end

  // Slave bit counter; select high or a mode change clears it at once.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I || !s_act) begin
      cnt_q <= 4'h0;
    end else if (smp) begin
      cnt_q <= done ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // Shift register: loads on a write, takes one bit per sample edge.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      sr_q <= SPIMSP_BYTE_RST;
    end else if (wr_ok) begin
      sr_q <= DATA_WDATA_I;
    end else if (smp) begin
      if (BIT_ORDER_I) begin
        sr_q <= {in_bit, sr_q[7:1]};
      end else begin
        sr_q <= {sr_q[6:0], in_bit};
      end
    end
  end

  // Output bit moves on setup edges and follows the next bit to send while idle, so it is stable at sampling.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      out_bit_q <= 1'b0;
    end else if (setup) begin
      out_bit_q <= top_bit;
    end else if (~busy) begin
      out_bit_q <= BIT_ORDER_I ? DATA_WDATA_I[0] : DATA_WDATA_I[7];
      if (!wr_ok) begin
        out_bit_q <= top_bit;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive buffer: overwritten by every completed byte, read or not.
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      RX_DATA_O <= SPIMSP_BYTE_RST;
    end else if (done) begin
      // In slave mode and master phase one the final sample lands in the same cycle, so merge it here.
      RX_DATA_O <= BIT_ORDER_I ? (smp ? {in_bit, sr_q[7:1]} : sr_q)
                               : (smp ? {sr_q[6:0], in_bit} : sr_q);
    end
  end

  // ----------------------------------------------------------------------
  // Flags. Status read with a flag set arms its clear; the next data
  // access then clears it. A set in the same cycle wins over any clear.
  // ----------------------------------------------------------------------
  logic done_arm_q; // Status was read with the done flag set.
  logic write_collision_flag_arm_q; // Status was read with the collision flag set.
  logic data_acc; // Data register read or written.

  assign data_acc = DATA_RD_I | DATA_WR_I;

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      TRANSFER_DONE_FLAG_O <= 1'b0;
      done_arm_q <= 1'b0;
    end else if (done || mode_fault) begin
      TRANSFER_DONE_FLAG_O <= 1'b1;
      done_arm_q <= 1'b0;
    end else if (IRQ_ACK_I || (data_acc && done_arm_q)) begin
      TRANSFER_DONE_FLAG_O <= 1'b0;
      done_arm_q <= 1'b0;
    end else if (STATUS_RD_I && TRANSFER_DONE_FLAG_O) begin
      done_arm_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      WRITE_COLLISION_FLAG_O <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
    end else if (en && DATA_WR_I && busy) begin
      WRITE_COLLISION_FLAG_O <= 1'b1;
      write_collision_flag_arm_q <= 1'b0;
    end else if (data_acc && write_collision_flag_arm_q) begin
      WRITE_COLLISION_FLAG_O <= 1'b0;
      write_collision_flag_arm_q <= 1'b0;
    end else if (STATUS_RD_I && WRITE_COLLISION_FLAG_O) begin
      write_collision_flag_arm_q <= 1'b1;
    end
  end

  // Interrupt request and visible state.
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      IRQ_O <= 1'b0;
      MASTER_SELECT_O <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      IRQ_O <= TRANSFER_DONE_FLAG_O & TRANSFER_IRQ_ENABLE_I &
               GLOBAL_IRQ_ENABLE_I;
      MASTER_SELECT_O <= master_q;
      BUSY_O <= busy;
    end
  end

  // ----------------------------------------------------------------------
  // Pin direction overrides. Enables are active low.
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      MOSI_O <= 1'b0;
      MISO_O <= 1'b0;
      SCK_O <= 1'b0;
      SEL_N_O <= 1'b1;
      {SEL_OE_N_O, SCK_OE_N_O, MISO_OE_N_O, MOSI_OE_N_O} <= 4'hF;
    end else begin
      // User values and directions apply unless overridden below.
      {SEL_N_O, SCK_O, MISO_O, MOSI_O} <= PIN_PORT_I;
      {SEL_OE_N_O, SCK_OE_N_O, MISO_OE_N_O, MOSI_OE_N_O} <= ~PIN_DIR_OUT_I;
      if (en && master_q && !mode_fault) begin
        MOSI_O <= out_bit_q;
        SCK_O <= sck_q;
        MISO_OE_N_O <= 1'b1;
      end else if (en) begin
        MOSI_OE_N_O <= 1'b1;
        SCK_OE_N_O <= 1'b1;
        SEL_OE_N_O <= 1'b1;
        MISO_O <= out_bit_q;
        MISO_OE_N_O <= ~(PIN_DIR_OUT_I[SPIMSP_PIN_MISO] & sel_low);
      end
    end
  end

endmodule

// File: common/spimsp_pkg.sv
// Package with constants and types for the serial master/slave port.
package spimsp_pkg;

  // ----------------------------------------------------------------------
  // Frame geometry.
  // ----------------------------------------------------------------------
  localparam int unsigned SPIMSP_BITS = 8; // Bits in one byte frame.
  localparam logic [3:0] SPIMSP_LAST_BIT = 4'h7; // Index of the last bit.
  localparam logic [4:0] SPIMSP_LAST_EDGE = 5'h0F; // 16 edges per byte.

  // ----------------------------------------------------------------------
  // Pin slots of the direction and port-value vectors.
  // ----------------------------------------------------------------------
  localparam int unsigned SPIMSP_PIN_MOSI = 0;
  localparam int unsigned SPIMSP_PIN_MISO = 1;
  localparam int unsigned SPIMSP_PIN_SCK = 2;
  localparam int unsigned SPIMSP_PIN_SEL = 3;

  // ----------------------------------------------------------------------
  // Master half-period counts in system clocks, indexed by the rate code.
  // Dividers 4, 16, 64, 128 give halves 2, 8, 32, 64; double speed halves.
  // ----------------------------------------------------------------------
  localparam logic [6:0] SPIMSP_HALF_0 = 7'h02;
  localparam logic [6:0] SPIMSP_HALF_1 = 7'h08;
  localparam logic [6:0] SPIMSP_HALF_2 = 7'h20;
  localparam logic [6:0] SPIMSP_HALF_3 = 7'h40;
  localparam logic [6:0] SPIMSP_HALF_2X_0 = 7'h01;
  localparam logic [6:0] SPIMSP_HALF_2X_1 = 7'h04;
  localparam logic [6:0] SPIMSP_HALF_2X_2 = 7'h10;
  localparam logic [6:0] SPIMSP_HALF_2X_3 = 7'h20;

  // ----------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------
  localparam logic [7:0] SPIMSP_BYTE_RST = 8'h00;

  // Master transfer state.
  typedef enum logic [0:0] {
    SPIMSP_IDLE = 1'b0,
    SPIMSP_XFER = 1'b1
  } spimsp_state_t;

endpackage

// File: rtl/spimsp_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/10ps
module spimsp_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [WIDTH-1:0] ASYNC_I,
  output logic [WIDTH-1:0] SYNC_O
);

  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------------
  // Two flops in series to settle metastable samples.
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      meta_q <= '0;
      SYNC_O <= '0;
    end else begin
      meta_q <= ASYNC_I;
      SYNC_O <= meta_q;
    end
  end

endmodule

// File: bench/spimsp_core_monitor.sv
// Checker of pin directions, flags and transfer timing of the serial port.
`timescale 1ns/10ps
module spimsp_core_monitor (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic SERIAL_POWER_REDUCE_I,
  input wire logic SERIAL_ENABLE_I,
  input wire logic TRANSFER_IRQ_ENABLE_I,
  input wire logic GLOBAL_IRQ_ENABLE_I,
  input wire logic DATA_WR_I,
  input wire logic IRQ_ACK_I,
  input wire logic [3:0] PIN_DIR_OUT_I,
  input wire logic SEL_N_I,
  input wire logic MOSI_OE_N_O,
  input wire logic MISO_OE_N_O,
  input wire logic SCK_OE_N_O,
  input wire logic SEL_OE_N_O,
  input wire logic [7:0] RX_DATA_O,
  input wire logic TRANSFER_DONE_FLAG_O,
  input wire logic WRITE_COLLISION_FLAG_O,
  input wire logic MASTER_SELECT_O,
  input wire logic BUSY_O,
  input wire logic IRQ_O
);
  // ----------------------------------------------------------------
  // Clocking, helper logic and sequences.
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // The port is live only when enabled and not power-reduced.
  logic on;
  assign on = SERIAL_ENABLE_I && !SERIAL_POWER_REDUCE_I;
  // Two live cycles let the registered pin enables catch up.
  sequence s_on2; on[*2]; endsequence
  // A low select input seen while acting as master.
  sequence s_fault;
    on && MASTER_SELECT_O && !PIN_DIR_OUT_I[3] && !SEL_N_I;
  endsequence
  // ----------------------------------------------------------------
  // Properties.
  // ----------------------------------------------------------------
  property p_off; SERIAL_POWER_REDUCE_I[*3] |-> !BUSY_O; endproperty
  a_off: assert property (p_off) else $error("busy while off");
  property p_start;
    on && MASTER_SELECT_O && DATA_WR_I && !BUSY_O |-> ##2 BUSY_O;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_end; $fell(BUSY_O) && MASTER_SELECT_O |-> TRANSFER_DONE_FLAG_O;
  endproperty
  a_end: assert property (p_end) else $error("no done flag");
  property p_irq;
    IRQ_O == $past(TRANSFER_DONE_FLAG_O && TRANSFER_IRQ_ENABLE_I
      && GLOBAL_IRQ_ENABLE_I);
  endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_write_collision_flag;
    on && BUSY_O && DATA_WR_I && MASTER_SELECT_O |=> WRITE_COLLISION_FLAG_O;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("no collision");
  property p_rx; $changed(RX_DATA_O) |-> TRANSFER_DONE_FLAG_O; endproperty
  a_rx: assert property (p_rx) else $error("stray rx update");
  property p_clr; IRQ_ACK_I && !BUSY_O && SEL_N_I |=> !TRANSFER_DONE_FLAG_O;
  endproperty
  a_clr: assert property (p_clr) else $error("ack kept flag");
  property p_mdir; s_on2 ##0 MASTER_SELECT_O[*2] |-> MISO_OE_N_O; endproperty
  a_mdir: assert property (p_mdir) else $error("miso driven");
  property p_sdir;
    s_on2 ##0 (!MASTER_SELECT_O)[*2] |-> MOSI_OE_N_O && SCK_OE_N_O
      && SEL_OE_N_O;
  endproperty
  a_sdir: assert property (p_sdir) else $error("slave pin out");
  property p_idle; s_on2 ##0 SEL_N_I[*5] |-> MISO_OE_N_O; endproperty
  a_idle: assert property (p_idle) else $error("miso not released");
  property p_fault;
    s_fault |-> ##[1:8] (!MASTER_SELECT_O && TRANSFER_DONE_FLAG_O);
  endproperty
  a_fault: assert property (p_fault) else $error("no fallback");
endmodule

// File: bench/spimsp_partner.sv
// Behavioural slave device that answers the port while it is master.
`timescale 1ns/10ps
module spimsp_partner (
  input wire logic SCK_I,
  input wire logic MOSI_I,
  input wire logic SEL_N_I,
  input wire logic CPOL_I,
  input wire logic CPHA_I,
  input wire logic LSB_I,
  input wire logic [7:0] TX_I,
  output logic MISO_O,
  output logic [7:0] RX_O
);
  // Bits sampled so far in this frame.
  logic [3:0] n = 4'h0;
  // Rises on the sample edge and falls on the setup edge, any mode.
  wire s = SCK_I ^ CPOL_I ^ CPHA_I;
  initial MISO_O = 1'b0;
  initial RX_O = 8'h00;
  function automatic logic pick(input logic [3:0] i);
    return LSB_I ? TX_I[i[2:0]] : TX_I[3'h7 - i[2:0]];
  endfunction
  // Select low starts the frame with the first bit on the line.
  always @(negedge SEL_N_I) begin
    n = 4'h0;
    MISO_O = pick(4'h0);
  end
  // Released line shows the inverse so a stale value cannot pass.
  always @(posedge SEL_N_I) MISO_O = ~MISO_O;
  always @(posedge s) begin
    if (!SEL_N_I) begin
      RX_O = LSB_I ? {MOSI_I, RX_O[7:1]} : {RX_O[6:0], MOSI_I};
      n = n + 4'h1;
    end
  end
  always @(negedge s) begin
    if (!SEL_N_I && n < 4'h8) MISO_O = pick(n);
  end
endmodule

// File: bench/spimsp_core_tb.sv
// Self-checking bench for the serial master/slave port.
`timescale 1ns/10ps
module spimsp_core_tb;
  // ----------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, pr = 1'b0, en = 1'b0, cpol = 1'b0;
  logic cpha = 1'b0, bo = 1'b0, msw = 1'b0, msv = 1'b0;
  logic s_mosi = 1'b0, s_sck = 1'b0, s_sel = 1'b1;
  logic [3:0] stb = 4'h0, dir = 4'h0, port = 4'h8;
  logic [7:0] wd = 8'h00, ptx = 8'h00, got = 8'h00;
  wire mosi_o, mosi_oe_n, miso_o, miso_oe_n, sck_o, sck_oe_n, sel_o;
  wire sel_oe_n, done, write_collision_flag, mst, busy, irq, p_miso;
  wire [7:0] rx, prx;
  int fails = 0, n_checks = 0;
  always #5 clk = ~clk;
  spimsp_core dut (.SYS_CLK_I(clk), .RESET_I(rst),
    .SERIAL_POWER_REDUCE_I(pr), .SERIAL_ENABLE_I(en),
    .TRANSFER_IRQ_ENABLE_I(1'b1), .GLOBAL_IRQ_ENABLE_I(1'b1),
    .BIT_ORDER_I(bo), .CLK_POL_I(cpol), .CLK_PHA_I(cpha),
    .RATE_SEL_I(2'b01), .DOUBLE_SPEED_I(1'b0), .MASTER_SELECT_WR_I(msw),
    .MASTER_SELECT_VAL_I(msv), .DATA_WR_I(stb[0]), .DATA_WDATA_I(wd),
    .DATA_RD_I(stb[1]), .STATUS_RD_I(stb[2]), .IRQ_ACK_I(stb[3]),
    .PIN_DIR_OUT_I(dir), .PIN_PORT_I(port), .MOSI_I(s_mosi),
    .MOSI_O(mosi_o), .MOSI_OE_N_O(mosi_oe_n), .MISO_I(p_miso),
    .MISO_O(miso_o), .MISO_OE_N_O(miso_oe_n), .SCK_I(s_sck),
    .SCK_O(sck_o), .SCK_OE_N_O(sck_oe_n), .SEL_N_I(s_sel),
    .SEL_N_O(sel_o), .SEL_OE_N_O(sel_oe_n), .RX_DATA_O(rx),
    .TRANSFER_DONE_FLAG_O(done), .WRITE_COLLISION_FLAG_O(write_collision_flag),
    .MASTER_SELECT_O(mst), .BUSY_O(busy), .IRQ_O(irq));
  spimsp_partner peer (.SCK_I(sck_o), .MOSI_I(mosi_o), .SEL_N_I(sel_o),
    .CPOL_I(cpol), .CPHA_I(cpha), .LSB_I(bo), .TX_I(ptx),
    .MISO_O(p_miso), .RX_O(prx));
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Called at a rising edge: the values seen are those that stood
  // through the cycle before it, so stimulus stays on the edge.
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One-cycle software strobe: bit 0 write, 1 read, 2 status, 3 ack.
  // A low cycle follows, so back-to-back calls never merge.
  task automatic strobe(input logic [3:0] m);
    stb <= m;
    tick(1);
    stb <= 4'h0;
    tick(1);
  endtask
  // Outside master, mode 0, MSB first; 80 ns link period.
  task automatic sbits(input logic [7:0] b, input int k);
    for (int i = 0; i < k; i++) begin
      s_mosi <= b[7 - i];
      tick(4);
      s_sck <= 1'b1;
      tick(4);
      got = {got[6:0], miso_o};
      s_sck <= 1'b0;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_master;
    en <= 1'b1; dir <= 4'hD; msv <= 1'b1; msw <= 1'b1; tick(1);
    msw <= 1'b0; s_sel <= 1'b0; tick(4);
    chk("mst", 8'h01, mst);
    pr <= 1'b1; wd <= 8'h11; strobe(4'h1); tick(4);
    chk("pr_busy", 8'h00, busy);
    pr <= 1'b0; tick(2);
    for (int m = 0; m < 4; m++) begin
      cpol <= m[1]; cpha <= m[0]; bo <= m[0]; ptx <= 8'hA5 ^ m[7:0];
      tick(2); port <= 4'h0; tick(2);
      chk("sel_out", 8'h00, sel_o);
      wd <= 8'h3C + m[7:0]; strobe(4'h1); tick(1);
      wd <= 8'hFF; strobe(4'h1);
      for (int i = 0; i < 300 && done !== 1'b1; i++) tick(1);
      tick(2);
      chk("m_rx", 8'hA5 ^ m[7:0], rx);
      chk("peer_rx", 8'h3C + m[7:0], prx);
      chk("m_flags", 8'h07, {irq, done, write_collision_flag});
      chk("m_mst", 8'h01, mst);
      port <= 4'h8; strobe(4'h2); tick(1);
      chk("order", 8'h01, done);
      strobe(4'h4); strobe(4'h2); tick(1);
      chk("clr", 8'h00, {done, write_collision_flag});
    end
    $display("master test finished");
  endtask
  task automatic t_fault;
    s_sel <= 1'b1; tick(6); dir <= 4'h5; tick(6);
    s_sel <= 1'b0; tick(10);
    chk("f_mst", 8'h00, mst);
    chk("f_done", 8'h03, {done, irq});
    chk("f_oe_n", 8'h07, {mosi_oe_n, sck_oe_n, sel_oe_n});
    s_sel <= 1'b1; tick(6); strobe(4'h8); tick(2);
    chk("ack", 8'h00, {done, irq});
    $display("fallback test finished");
  endtask
  task automatic t_slave;
    dir <= 4'h2; cpol <= 1'b0; cpha <= 1'b0; bo <= 1'b0;
    sbits(8'hFF, 8);
    chk("idle", 8'h01, {done, miso_oe_n});
    wd <= 8'h96; strobe(4'h1);
    s_sel <= 1'b0; tick(6);
    chk("act_oe_n", 8'h00, miso_oe_n);
    sbits(8'h5A, 8); tick(6);
    chk("s_rx", 8'h5A, rx);
    chk("s_tx", 8'h96, got);
    chk("s_done", 8'h03, {done, irq});
    sbits(8'h0F, 3); s_sel <= 1'b1; tick(6); s_sel <= 1'b0; tick(6);
    sbits(8'hC3, 8); tick(6);
    chk("s_rx2", 8'hC3, rx);
    s_sel <= 1'b1; tick(6);
    chk("rel_oe_n", 8'h01, miso_oe_n);
    $display("slave test finished");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence: reset, then each scenario in turn.
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(2);
    chk("rst_rx", 8'h00, rx);
    chk("rst_fl", 8'h00, {done, write_collision_flag, mst, busy, irq});
    chk("rst_oe", 8'h0F, {mosi_oe_n, miso_oe_n, sck_oe_n, sel_oe_n});
    $display("reset test finished");
    t_master;
    t_fault;
    t_slave;
    end_sim;
  end
  // Watchdog: the whole run needs a little under a tenth of this span.
  initial begin
    #100000;
    fails++;
    end_sim;
  end
endmodule
bind spimsp_core spimsp_core_monitor mon (.*);
